// ### src/dac_channel_config_and_software_reg.v
`timescale 1ns/1ps
`include "cfg_block_defs.vh"

// Behaviour
// - The 20 percent overrange is active only when its enable bit is set and a voltage range is chosen, and the enable resets to off.
// - Range codes 000, 001, 010 and 011 select 0-5 V (default), 0-10 V, bipolar 5 V and bipolar 10 V.
// - Range codes 100 and 101 select the 4-20 mA and 0-20 mA current outputs.
// - A word whose top three bits are 100 goes to the software command register, bit 12 being the toggle and bits 11-0 the code.
// - Each software command write, except one made while a soft reset is still clearing, copies its bit 12 into user_toggle_status.
// - Code 0x555 in a software command write resets the whole part.
// - With the watchdog on, a missing service write within the timeout raises the fault alert, and never while it is off.
module dac_channel_config_and_software_reg #(
	parameter TIMEOUT_CYCLES = `WDOG_TIMEOUT_US * `CLK_MHZ,
	parameter CNT_W = 20
) (
	input wire clk,
	input wire resetn,
	input wire word_valid,
	input wire [`WORD_W-1:0] word_data,
	input wire ctrl_valid,
	input wire [1:0] ctrl_channel,
	input wire [3:0] ctrl_bits,
	input wire watchdog_enable,
	output reg [`MODE_W-1:0] ch0_mode,
	output reg ch0_is_current,
	output reg ch0_overrange,
	output reg [`MODE_W-1:0] ch1_mode,
	output reg ch1_is_current,
	output reg ch1_overrange,
	output reg [`MODE_W-1:0] ch2_mode,
	output reg ch2_is_current,
	output reg ch2_overrange,
	output reg [`MODE_W-1:0] ch3_mode,
	output reg ch3_is_current,
	output reg ch3_overrange,
	output reg user_toggle_status,
	output reg part_reset,
	output reg fault_alert
);

	// ==============================
	// helpers
	function is_software_word;
		input [`WORD_W-1:0] w;
		begin
			is_software_word = (w[`SEL_HI:`SEL_LO] == `SEL_SOFTWARE);
		end
	endfunction

	// the count may be narrower than an integer, so the last count is cut to it on purpose
	localparam integer LAST_COUNT = TIMEOUT_CYCLES - 1;
	localparam [CNT_W-1:0] TIMEOUT_LAST = LAST_COUNT[CNT_W-1:0];

	// ==============================
	// per-channel setting storage
	reg [2:0] range_sel [0:3];
	reg ovr_en [0:3];
	reg [3:0] reset_left;
	reg [3:0] next_reset_left;
	wire soft_clear;
	integer i;

	assign soft_clear = (reset_left != 4'h0);

	// soft reset returns every channel to 0-5 V with overrange off
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (i = 0; i < 4; i = i + 1) begin
				range_sel[i] <= `RANGE_0_5V;
				ovr_en[i] <= 1'b0;
			end
		end else if (soft_clear) begin
			for (i = 0; i < 4; i = i + 1) begin
				range_sel[i] <= `RANGE_0_5V;
				ovr_en[i] <= 1'b0;
			end
		end else if (ctrl_valid) begin
			range_sel[ctrl_channel] <= ctrl_bits[`RANGE_HI:`RANGE_LO];
			ovr_en[ctrl_channel] <= ctrl_bits[`OVR_BIT];
		end
	end

	// ==============================
	// channel decoders
	wire [`MODE_W-1:0] dec_mode [0:3];
	wire dec_cur [0:3];
	wire dec_ovr [0:3];

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : chan
			range_decoder u_dec (
				.clk(clk),
				.resetn(resetn),
				.output_range_select(range_sel[g]),
				.overrange_enable(ovr_en[g]),
				.mode(dec_mode[g]),
				.is_current(dec_cur[g]),
				.overrange_active(dec_ovr[g])
			);
		end
	endgenerate

	// outputs re-registered so each top port comes from its own flop
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ch0_mode <= `MODE_V5;
			ch1_mode <= `MODE_V5;
			ch2_mode <= `MODE_V5;
			ch3_mode <= `MODE_V5;
			ch0_is_current <= 1'b0;
			ch1_is_current <= 1'b0;
			ch2_is_current <= 1'b0;
			ch3_is_current <= 1'b0;
			ch0_overrange <= 1'b0;
			ch1_overrange <= 1'b0;
			ch2_overrange <= 1'b0;
			ch3_overrange <= 1'b0;
		end else begin
			ch0_mode <= dec_mode[0];
			ch1_mode <= dec_mode[1];
			ch2_mode <= dec_mode[2];
			ch3_mode <= dec_mode[3];
			ch0_is_current <= dec_cur[0];
			ch1_is_current <= dec_cur[1];
			ch2_is_current <= dec_cur[2];
			ch3_is_current <= dec_cur[3];
			ch0_overrange <= dec_ovr[0];
			ch1_overrange <= dec_ovr[1];
			ch2_overrange <= dec_ovr[2];
			ch3_overrange <= dec_ovr[3];
		end
	end

	// ==============================
	// software command register
	wire sw_write;
	wire [11:0] sw_code;
	wire do_reset;
	wire do_service;

	assign sw_write = word_valid && is_software_word(word_data);
	assign sw_code = word_data[`CODE_HI:`CODE_LO];
	assign do_reset = sw_write && (sw_code == `CODE_RESET);
	assign do_service = sw_write && (sw_code == `CODE_SERVICE);

	// toggle bit mirror; a full reset clears it too
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			user_toggle_status <= 1'b0;
		end else if (soft_clear) begin
			user_toggle_status <= 1'b0;
		end else if (sw_write) begin
			user_toggle_status <= word_data[`TOGGLE_BIT];
		end
	end

	// reload on a reset code, else run down to zero; a second reset code restarts the pulse
	always @* begin
		next_reset_left = reset_left;
		if (do_reset) begin
			next_reset_left = `RESET_PULSE_CYCLES;
		end else if (soft_clear) begin
			next_reset_left = reset_left - 4'h1;
		end
	end

	// reset pulse held a few cycles so the rest of the part sees it cleanly
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reset_left <= 4'h0;
			part_reset <= 1'b0;
		end else begin
			reset_left <= next_reset_left;
			part_reset <= do_reset || (reset_left > 4'h1);
		end
	end

	// ==============================
	// watchdog
	// the counter parks at its last value so a held alert never wraps back to quiet
	reg [CNT_W-1:0] wd_count;
	reg [CNT_W-1:0] next_wd_count;
	reg next_fault_alert;
	wire wd_expired;

	assign wd_expired = (wd_count == TIMEOUT_LAST);

	// next-state choice; disable and soft reset outrank a service write
	always @* begin
		next_wd_count = wd_count;
		next_fault_alert = fault_alert;
		if (!watchdog_enable || soft_clear) begin
			next_wd_count = {CNT_W{1'b0}};
			next_fault_alert = 1'b0;
		end else if (do_service) begin
			// service in the expiry cycle wins, so a host that is just in time is never faulted
			next_wd_count = {CNT_W{1'b0}};
			next_fault_alert = 1'b0;
		end else if (wd_expired) begin
			next_fault_alert = 1'b1;
		end else begin
			next_wd_count = wd_count + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// count only while enabled; alert stays until serviced, disabled or cleared by a soft reset
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wd_count <= {CNT_W{1'b0}};
			fault_alert <= 1'b0;
		end else begin
			wd_count <= next_wd_count;
			fault_alert <= next_fault_alert;
		end
	end

endmodule

// ### include/cfg_block_defs.vh
`ifndef CFG_BLOCK_DEFS_VH
`define CFG_BLOCK_DEFS_VH

// ==============================
// data word layout
`define WORD_W 16
`define SEL_HI 15
`define SEL_LO 13
`define SEL_SOFTWARE 3'h4
`define TOGGLE_BIT 12
`define CODE_HI 11
`define CODE_LO 0
`define CODE_RESET 12'h555
`define CODE_SERVICE 12'h195

// ==============================
// channel control word fields
`define RANGE_HI 2
`define RANGE_LO 0
`define OVR_BIT 3
`define RANGE_0_5V 3'h0
`define RANGE_0_10V 3'h1
`define RANGE_PM5V 3'h2
`define RANGE_PM10V 3'h3
`define RANGE_4_20MA 3'h4
`define RANGE_0_20MA 3'h5

// ==============================
// decoded mode codes
`define MODE_W 3
`define MODE_V5 3'h0
`define MODE_V10 3'h1
`define MODE_VPM5 3'h2
`define MODE_VPM10 3'h3
`define MODE_I4_20 3'h4
`define MODE_I0_20 3'h5
`define MODE_OFF 3'h7

// ==============================
// watchdog and reset pulse timing
`define WDOG_TIMEOUT_US 1000
`define CLK_MHZ 125
`define RESET_PULSE_CYCLES 4'h4

`endif

// ### src/range_decoder.v
`timescale 1ns/1ps
`include "cfg_block_defs.vh"

// registered decode of one channel's range and overrange setting
module range_decoder (
	input wire clk,
	input wire resetn,
	input wire [2:0] output_range_select,
	input wire overrange_enable,
	output reg [`MODE_W-1:0] mode,
	output reg is_current,
	output reg overrange_active
);

	// ==============================
	// decode
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mode <= `MODE_V5;
			is_current <= 1'b0;
			overrange_active <= 1'b0;
		end else begin
			case (output_range_select)
				`RANGE_0_5V: begin
					mode <= `MODE_V5;
					is_current <= 1'b0;
					overrange_active <= overrange_enable;
				end
				`RANGE_0_10V: begin
					mode <= `MODE_V10;
					is_current <= 1'b0;
					overrange_active <= overrange_enable;
				end
				`RANGE_PM5V: begin
					mode <= `MODE_VPM5;
					is_current <= 1'b0;
					overrange_active <= overrange_enable;
				end
				`RANGE_PM10V: begin
					mode <= `MODE_VPM10;
					is_current <= 1'b0;
					overrange_active <= overrange_enable;
				end
				`RANGE_4_20MA: begin
					mode <= `MODE_I4_20;
					is_current <= 1'b1;
					overrange_active <= 1'b0;
				end
				`RANGE_0_20MA: begin
					mode <= `MODE_I0_20;
					is_current <= 1'b1;
					overrange_active <= 1'b0;
				end
				default: begin
					// undefined codes leave the output unpowered, never overranged
					mode <= `MODE_OFF;
					is_current <= 1'b0;
					overrange_active <= 1'b0;
				end
			endcase
		end
	end

endmodule

// ### verif/cfg_checker_assertions.sv
`timescale 1ns/1ps
// ==============================
// checker on the block's ports
module cfg_checker #(
	parameter TIMEOUT_CYCLES = 20
) (
	input wire clk,
	input wire resetn,
	input wire word_valid,
	input wire [15:0] word_data,
	input wire ctrl_valid,
	input wire [1:0] ctrl_channel,
	input wire [3:0] ctrl_bits,
	input wire watchdog_enable,
	input wire [2:0] ch0_mode,
	input wire ch0_overrange,
	input wire user_toggle_status,
	input wire part_reset,
	input wire fault_alert
);
	reg [7:0] idle;
	wire svc = word_valid && word_data == {3'h4, word_data[12], 12'h195};
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_sw;
		word_valid && word_data[15:13] == 3'h4;
	endsequence
	sequence s_ch0;
		ctrl_valid && ctrl_channel == 2'h0 && !part_reset;
	endsequence
	// cycles since service or switch-on; saturates so a long idle never wraps to a false quiet
	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			idle <= 8'h00;
		else if (!watchdog_enable || part_reset || svc)
			idle <= 8'h00;
		else if (idle != 8'hFF)
			idle <= idle + 8'h01;
	end
	// decode appears three edges after the setting is taken
	property p_mode;
		logic [2:0] r;
		(s_ch0, r = ctrl_bits[2:0]) |-> ##3 ch0_mode == (r > 3'h5 ? 3'h7 : r);
	endproperty
	a_mode: assert property (p_mode) else $error("mode decode");
	property p_ovr;
		logic [3:0] b;
		(s_ch0, b = ctrl_bits) |-> ##3 ch0_overrange == (b[3] && !b[2]);
	endproperty
	a_ovr: assert property (p_ovr) else $error("overrange");
	property p_tog;
		s_sw ##0 word_data[11:0] != 12'h555 |=> user_toggle_status == $past(word_data[12]);
	endproperty
	a_tog: assert property (p_tog) else $error("toggle copy");
	property p_ign;
		word_valid && word_data[15:13] != 3'h4 && !part_reset |=> $stable(user_toggle_status);
	endproperty
	a_ign: assert property (p_ign) else $error("foreign word");
	property p_rst;
		s_sw ##0 word_data[11:0] == 12'h555 |=> part_reset [*4] ##1 !part_reset;
	endproperty
	a_rst: assert property (p_rst) else $error("reset pulse");
	property p_clr;
		$fell(part_reset) |-> ch0_mode == 3'h0 && !user_toggle_status && !fault_alert;
	endproperty
	a_clr: assert property (p_clr) else $error("reset clear");
	property p_fire;
		idle > TIMEOUT_CYCLES |-> fault_alert;
	endproperty
	a_fire: assert property (p_fire) else $error("no alert");
	property p_early;
		idle < TIMEOUT_CYCLES - 1 |-> !fault_alert;
	endproperty
	a_early: assert property (p_early) else $error("early alert");
endmodule

bind dac_channel_config_and_software_reg cfg_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_cfg_checker (
	.clk(clk),
	.resetn(resetn),
	.word_valid(word_valid),
	.word_data(word_data),
	.ctrl_valid(ctrl_valid),
	.ctrl_channel(ctrl_channel),
	.ctrl_bits(ctrl_bits),
	.watchdog_enable(watchdog_enable),
	.ch0_mode(ch0_mode),
	.ch0_overrange(ch0_overrange),
	.user_toggle_status(user_toggle_status),
	.part_reset(part_reset),
	.fault_alert(fault_alert)
);

// ### verif/host_model.sv
`timescale 1ns/1ps
// ==============================
// serial host handing whole words to the block
module host_model (
	input wire clk,
	output reg word_valid,
	output reg [15:0] word_data
);
	initial begin
		word_valid = 1'b0;
		word_data = 16'h0000;
	end
	// one word for one cycle; lines then inverted so a stale word never looks held
	task send(input [15:0] w);
		begin
			@(negedge clk);
			word_valid = 1'b1;
			word_data = w;
			@(negedge clk);
			word_valid = 1'b0;
			word_data = ~w;
		end
	endtask
	// service writes every ten cycles, well inside the timeout
	task service(input integer n);
		begin
			repeat (n) begin
				send(16'h8195);
				repeat (8) @(negedge clk);
			end
		end
	endtask
endmodule

// ### verif/test_dac_channel_config_and_software_reg.sv
`timescale 1ns/1ps
// ==============================
// bench
module test_dac_channel_config_and_software_reg;
	reg clk = 1'b0;
	reg resetn = 1'b0;
	reg ctrl_valid = 1'b0;
	reg [1:0] ctrl_channel = 2'h0;
	reg [3:0] ctrl_bits = 4'h0;
	reg watchdog_enable = 1'b0;
	reg [2:0] m;
	wire word_valid;
	wire [15:0] word_data;
	wire [2:0] ch0_mode, ch1_mode, ch2_mode, ch3_mode;
	wire ch0_is_current, ch1_is_current, ch2_is_current, ch3_is_current;
	wire ch0_overrange, ch1_overrange, ch2_overrange, ch3_overrange;
	wire user_toggle_status, part_reset, fault_alert;
	wire [19:0] obs = {ch3_mode, ch3_is_current, ch3_overrange, ch2_mode, ch2_is_current, ch2_overrange,
		ch1_mode, ch1_is_current, ch1_overrange, ch0_mode, ch0_is_current, ch0_overrange};
	integer num_errors = 0;
	integer check_count = 0;
	integer i;
	// short timeout keeps the watchdog scenario brief
	dac_channel_config_and_software_reg #(
		.TIMEOUT_CYCLES(20),
		.CNT_W(8)
	) u_dac_channel_config_and_software_reg (
		.clk(clk),
		.resetn(resetn),
		.word_valid(word_valid),
		.word_data(word_data),
		.ctrl_valid(ctrl_valid),
		.ctrl_channel(ctrl_channel),
		.ctrl_bits(ctrl_bits),
		.watchdog_enable(watchdog_enable),
		.ch0_mode(ch0_mode),
		.ch0_is_current(ch0_is_current),
		.ch0_overrange(ch0_overrange),
		.ch1_mode(ch1_mode),
		.ch1_is_current(ch1_is_current),
		.ch1_overrange(ch1_overrange),
		.ch2_mode(ch2_mode),
		.ch2_is_current(ch2_is_current),
		.ch2_overrange(ch2_overrange),
		.ch3_mode(ch3_mode),
		.ch3_is_current(ch3_is_current),
		.ch3_overrange(ch3_overrange),
		.user_toggle_status(user_toggle_status),
		.part_reset(part_reset),
		.fault_alert(fault_alert)
	);
	host_model u_host_model (
		.clk(clk),
		.word_valid(word_valid),
		.word_data(word_data)
	);
	initial begin
		forever #4 clk = ~clk;
	end
	task chk(input [8*8-1:0] name, input [19:0] exp, input [19:0] got);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("BAD %0s expected %h seen %h", name, exp, got);
			end
		end
	endtask
	// every range code with overrange asked for, spread over the channels
	task t_range;
		begin
			chk("default", 20'h0, obs);
			for (i = 0; i < 8; i = i + 1) begin
				@(negedge clk);
				ctrl_valid = 1'b1;
				ctrl_channel = i[1:0];
				ctrl_bits = {1'b1, i[2:0]};
				@(negedge clk);
				ctrl_valid = 1'b0;
				repeat (3) @(negedge clk);
				m = (i > 5) ? 3'h7 : i[2:0];
				chk("range", {m, i > 3 && i < 6, i < 4}, obs[(i % 4) * 5 +: 5]);
			end
			// a voltage range with the enable clear must not overrange
			@(negedge clk);
			ctrl_valid = 1'b1;
			ctrl_channel = 2'h3;
			ctrl_bits = 4'h1;
			@(negedge clk);
			ctrl_valid = 1'b0;
			repeat (3) @(negedge clk);
			chk("ovr_off", 20'h04, obs[19:15]);
		end
	endtask
	task t_toggle;
		begin
			u_host_model.send(16'h90AB);
			@(negedge clk);
			chk("toggle", 20'h1, user_toggle_status);
			chk("keep", 20'h16, obs[9:5]);
			u_host_model.send(16'h3FFF);
			@(negedge clk);
			chk("foreign", 20'h1, user_toggle_status);
			u_host_model.send(16'h8000);
			@(negedge clk);
			chk("toggle", 20'h0, user_toggle_status);
		end
	endtask
	task t_reset;
		begin
			u_host_model.send(16'h9555);
			@(negedge clk);
			chk("pulse", 20'h1, part_reset);
			repeat (4) @(negedge clk);
			chk("cleared", 20'h0, {part_reset, user_toggle_status, obs[17:0]});
		end
	endtask
	task t_wd;
		begin
			watchdog_enable = 1'b1;
			u_host_model.service(6);
			chk("early", 20'h0, fault_alert);
			repeat (24) @(negedge clk);
			chk("alert", 20'h1, fault_alert);
			u_host_model.send(16'h8195);
			@(negedge clk);
			chk("service", 20'h0, fault_alert);
			watchdog_enable = 1'b0;
			repeat (30) @(negedge clk);
			chk("off", 20'h0, fault_alert);
		end
	endtask
	task results;
		begin
			$display("checks %0d errors %0d", check_count, num_errors);
			if (num_errors == 0 && check_count > 0) begin
				$display("Run complete: PASS");
			end else begin
				$display("Run complete: FAIL");
			end
			$finish;
		end
	endtask
	initial begin
		repeat (10) @(negedge clk);
		resetn = 1'b1;
		t_range;
		t_toggle;
		t_reset;
		t_wd;
		results;
	end
	// a hang ends the run as a failure
	initial begin
		#20000;
		num_errors = num_errors + 1;
		results;
	end
endmodule
